// ### hw/msr_defines.vh
// Constants for the motion stop reaction block
// Summary of operation
// (RULE1) Halt interrupts motion, resumes when withdrawn
// (RULE2) Halt from input pin or fieldbus
// (RULE3) Halt code 1 ramp, 3 torque
// (RULE4) Selector writes refused during deceleration ramp
// (RULE5) Halt limit: min halt, motor, stage, I2t
// (RULE6) Halt current 16-bit, 0.01 A, immediate
// (RULE7) Quick stop on class 1/2 or command
// (RULE8) Quick stop codes -2,-1,6,7; reset 6
// (RULE9) Quick stop uses its rate or current
// (RULE10) Quick rate 1..2^31-1, default 6000, next start
// (RULE11) Quick limit: min quick, motor, stage, I2t
// (RULE12) Halt rate default 600, zero ignored
// (RULE13) End state only after standstill
`ifndef MSR_DEFINES_VH
`define MSR_DEFINES_VH
// Parameter addresses
`define MSR_ADDR_QS_RATE 16'h0624
`define MSR_ADDR_HALT_SEL 16'h062e
`define MSR_ADDR_QS_SEL 16'h0630
`define MSR_ADDR_HALT_RATE 16'h0616
`define MSR_ADDR_QS_CUR 16'h111a
`define MSR_ADDR_HALT_CUR 16'h111c
// Reset values
`define MSR_RST_QS_RATE 32'h00001770
`define MSR_RST_HALT_RATE 32'h00000258
`define MSR_RST_HALT_SEL 16'h0001
`define MSR_RST_QS_SEL 16'h0006
// Option codes
`define MSR_HALT_DECEL 16'h0001
`define MSR_HALT_TORQUE 16'h0003
`define MSR_QS_TORQ_FAULT 16'hfffe
`define MSR_QS_DEC_FAULT 16'hffff
`define MSR_QS_DEC_HOLD 16'h0006
`define MSR_QS_TORQ_HOLD 16'h0007
// Rate range
`define MSR_RATE_MAX 32'h7fffffff
// Operating state numbers
`define MSR_OPST_QS_ACTIVE 4'h7
`define MSR_OPST_FAULT 4'h9
`endif

// ### hw/msr_motion_stop_reaction.v
// Halt and quick stop reaction logic with its parameter registers
`timescale 1ns/1ps
`include "msr_defines.vh"

module msr_motion_stop_reaction #(
  parameter [15:0] HALT_CUR_RESET = 16'h0000, // Stage peak at commissioning
  parameter [15:0] QS_CUR_RESET = 16'h0000
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Parameter access port
  input wire [15:0] parAddr,
  input wire [31:0] parWrData,
  input wire parWrEn,
  input wire parRdEn,
  output reg [31:0] parRdData,
  output reg parAck,
  output reg parErr,
  // Stop requests
  input wire haltPin,
  input wire haltCmd,
  input wire errClass1,
  input wire errClass2,
  input wire quickStopCmd,
  input wire stopClear,
  // Motion generator status
  input wire motionStart,
  input wire motorStandstill,
  // Current limits from elsewhere
  input wire [15:0] motorMaxCurrent,
  input wire [15:0] stagePeakCurrent,
  input wire [15:0] i2tCurrent,
  // Stop reaction outputs
  output reg haltActive,
  output reg quickStopActive,
  output reg torqueRamp,
  output reg decelRampRunning,
  output reg [31:0] activeDecelRate,
  output reg [15:0] activeCurrentLimit,
  output reg [3:0] opState,
  output reg faultState
);

  // Controller states
  localparam [2:0] ST_RUN = 3'd0;
  localparam [2:0] ST_HALT_RAMP = 3'd1;
  localparam [2:0] ST_HALT_HELD = 3'd2;
  localparam [2:0] ST_QS_RAMP = 3'd3;
  localparam [2:0] ST_QS_HOLD = 3'd4;
  localparam [2:0] ST_FAULT = 3'd5;

  // Smallest of two unsigned currents
  function [15:0] min2;
    input [15:0] a;
    input [15:0] b;
    begin
      min2 = (a < b) ? a : b;
    end
  endfunction

  // Quick stop code selects the torque ramp
  function qsTorque;
    input [15:0] code;
    begin
      qsTorque = (code == `MSR_QS_TORQ_FAULT) || (code == `MSR_QS_TORQ_HOLD);
    end
  endfunction

  // Parameter registers
  reg [31:0] qsRate_r;
  reg [31:0] haltRate_r;
  reg [15:0] haltSel_r;
  reg [15:0] qsSel_r;
  reg [15:0] haltCur_r;
  reg [15:0] qsCur_r;
  // Rates latched at motion start
  reg [31:0] qsRateApplied_r;
  reg [31:0] haltRateApplied_r;
  // Halt pin synchroniser
  reg haltSync1_r;
  reg haltSync2_r;
  // Controller state
  reg [2:0] state_r;
  reg [2:0] state_nxt;

  // Decoded requests
  wire haltReq = haltSync2_r | haltCmd; // [RULE2]
  wire qsReq = errClass1 | errClass2 | quickStopCmd; // [RULE7]
  wire inHalt = (state_r == ST_HALT_RAMP) || (state_r == ST_HALT_HELD);
  wire qsIsTorque = qsTorque(qsSel_r);
  wire haltIsTorque = (haltSel_r == `MSR_HALT_TORQUE);
  // Deceleration ramp currently braking the motor
  wire decelRunning = ((state_r == ST_HALT_RAMP) && !haltIsTorque) ||
                      ((state_r == ST_QS_RAMP) && !qsIsTorque);

  // Write acceptance checks
  wire wrData16Hi0 = (parWrData[31:16] == 16'h0000);
  wire haltSelOk = wrData16Hi0 && ((parWrData[15:0] == `MSR_HALT_DECEL) ||
                   (parWrData[15:0] == `MSR_HALT_TORQUE)); // [RULE3]
  wire qsSelOk = (parWrData[15:0] == `MSR_QS_TORQ_FAULT) ||
                 (parWrData[15:0] == `MSR_QS_DEC_FAULT) ||
                 (parWrData[15:0] == `MSR_QS_DEC_HOLD) ||
                 (parWrData[15:0] == `MSR_QS_TORQ_HOLD); // [RULE8]
  wire rateOk = (parWrData != 32'h00000000) && (parWrData <= `MSR_RATE_MAX); // [RULE10]

  // Address decode
  wire hitQsRate = (parAddr == `MSR_ADDR_QS_RATE);
  wire hitHaltRate = (parAddr == `MSR_ADDR_HALT_RATE);
  wire hitHaltSel = (parAddr == `MSR_ADDR_HALT_SEL);
  wire hitQsSel = (parAddr == `MSR_ADDR_QS_SEL);
  wire hitHaltCur = (parAddr == `MSR_ADDR_HALT_CUR);
  wire hitQsCur = (parAddr == `MSR_ADDR_QS_CUR);
  wire hitAny = hitQsRate | hitHaltRate | hitHaltSel | hitQsSel | hitHaltCur | hitQsCur;

  // Write is refused when value is illegal or ramp blocks it
  reg wrRefuse;
  always @*
  begin
    wrRefuse = 1'b0;
    if (!hitAny)
      wrRefuse = 1'b1;
    else if (hitHaltSel)
      wrRefuse = !haltSelOk || decelRunning; // [RULE4]
    else if (hitQsSel)
      wrRefuse = !qsSelOk || decelRunning; // [RULE4]
    else if (hitQsRate)
      wrRefuse = !rateOk;
    else if (hitHaltRate)
      wrRefuse = !rateOk; // Zero leaves the value unchanged [RULE12]
    else
      wrRefuse = !wrData16Hi0; // Currents are plain 16-bit [RULE6]
  end

  wire wrGo = parWrEn && !wrRefuse;

  // Halt pin passes two flip-flops before use
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      haltSync1_r <= 1'b0;
      haltSync2_r <= 1'b0;
    end
    else
    begin
      haltSync1_r <= haltPin;
      haltSync2_r <= haltSync1_r;
    end
  end

  // Parameter storage, changes to selectors and currents act at once
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      qsRate_r <= `MSR_RST_QS_RATE;
      haltRate_r <= `MSR_RST_HALT_RATE;
      haltSel_r <= `MSR_RST_HALT_SEL;
      qsSel_r <= `MSR_RST_QS_SEL;
      haltCur_r <= HALT_CUR_RESET;
      qsCur_r <= QS_CUR_RESET;
    end
    else if (wrGo)
    begin
      if (hitQsRate)
        qsRate_r <= parWrData; // [RULE10]
      if (hitHaltRate)
        haltRate_r <= parWrData; // [RULE12]
      if (hitHaltSel)
        haltSel_r <= parWrData[15:0]; // [RULE3]
      if (hitQsSel)
        qsSel_r <= parWrData[15:0]; // [RULE8]
      if (hitHaltCur)
        haltCur_r <= parWrData[15:0]; // [RULE6]
      if (hitQsCur)
        qsCur_r <= parWrData[15:0];
    end
  end

  // Rates take effect only when the next movement starts
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      qsRateApplied_r <= `MSR_RST_QS_RATE;
      haltRateApplied_r <= `MSR_RST_HALT_RATE;
    end
    else if (motionStart)
    begin
      qsRateApplied_r <= qsRate_r; // [RULE10]
      haltRateApplied_r <= haltRate_r;
    end
  end

  // Read data and acknowledge, one cycle after the strobe
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      parRdData <= 32'h00000000;
      parAck <= 1'b0;
      parErr <= 1'b0;
    end
    else
    begin
      parAck <= parWrEn | parRdEn;
      parErr <= (parWrEn && wrRefuse) || (parRdEn && !hitAny);
      if (parRdEn)
      begin
        if (hitQsRate)
          parRdData <= qsRate_r;
        else if (hitHaltRate)
          parRdData <= haltRate_r;
        else if (hitHaltSel)
          parRdData <= {16'h0000, haltSel_r};
        else if (hitQsSel)
          parRdData <= {{16{qsSel_r[15]}}, qsSel_r}; // Signed code
        else if (hitHaltCur)
          parRdData <= {16'h0000, haltCur_r};
        else if (hitQsCur)
          parRdData <= {16'h0000, qsCur_r};
        else
          parRdData <= 32'h00000000;
      end
    end
  end

  // Stop sequencing; quick stop outranks halt
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
      begin
        if (qsReq)
          state_nxt = ST_QS_RAMP; // [RULE7]
        else if (haltReq)
          state_nxt = ST_HALT_RAMP; // [RULE1]
      end
      ST_HALT_RAMP, ST_HALT_HELD:
      begin
        if (qsReq)
          state_nxt = ST_QS_RAMP; // [RULE7]
        else if (!haltReq)
          state_nxt = ST_RUN; // Movement may resume [RULE1]
        else if (motorStandstill)
          state_nxt = ST_HALT_HELD;
      end
      ST_QS_RAMP:
      begin
        // End state waits for standstill [RULE13]
        if (motorStandstill)
        begin
          if (qsSel_r == `MSR_QS_TORQ_FAULT || qsSel_r == `MSR_QS_DEC_FAULT)
            state_nxt = ST_FAULT; // [RULE8]
          else
            state_nxt = ST_QS_HOLD; // [RULE8]
        end
      end
      ST_QS_HOLD, ST_FAULT:
      begin
        // Left only by an explicit clear from the controller
        if (stopClear && !qsReq)
          state_nxt = ST_RUN;
      end
      default:
        state_nxt = ST_RUN;
    endcase
  end

  // State register
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Limit from the next state so outputs match the state register
  wire nxtHalt = (state_nxt == ST_HALT_RAMP) || (state_nxt == ST_HALT_HELD);
  wire nxtQs = (state_nxt == ST_QS_RAMP) || (state_nxt == ST_QS_HOLD) ||
               (state_nxt == ST_FAULT);
  wire [15:0] baseLimit = min2(min2(motorMaxCurrent, stagePeakCurrent), i2tCurrent);
  wire [15:0] haltLimit = min2(haltCur_r, baseLimit); // [RULE5]
  wire [15:0] qsLimit = min2(qsCur_r, baseLimit); // [RULE11]
  wire nxtDecel = ((state_nxt == ST_HALT_RAMP) && !haltIsTorque) ||
                  ((state_nxt == ST_QS_RAMP) && !qsIsTorque);

  // Registered outputs toward the motion generator and current loop
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      haltActive <= 1'b0;
      quickStopActive <= 1'b0;
      torqueRamp <= 1'b0;
      decelRampRunning <= 1'b0;
      activeDecelRate <= `MSR_RST_HALT_RATE;
      activeCurrentLimit <= 16'h0000;
      opState <= 4'h0;
      faultState <= 1'b0;
    end
    else
    begin
      haltActive <= nxtHalt; // [RULE1]
      quickStopActive <= nxtQs;
      decelRampRunning <= nxtDecel;
      if (nxtQs)
      begin
        torqueRamp <= qsIsTorque; // [RULE9]
        activeDecelRate <= qsRateApplied_r; // [RULE9]
        activeCurrentLimit <= qsLimit; // [RULE11]
      end
      else if (nxtHalt)
      begin
        torqueRamp <= haltIsTorque; // [RULE3]
        activeDecelRate <= haltRateApplied_r;
        activeCurrentLimit <= haltLimit; // [RULE5]
      end
      else
      begin
        torqueRamp <= 1'b0;
        activeDecelRate <= haltRateApplied_r;
        activeCurrentLimit <= baseLimit;
      end
      if (state_nxt == ST_FAULT)
        opState <= `MSR_OPST_FAULT; // [RULE13]
      else if (state_nxt == ST_QS_HOLD)
        opState <= `MSR_OPST_QS_ACTIVE; // [RULE13]
      else
        opState <= 4'h0;
      faultState <= (state_nxt == ST_FAULT);
    end
  end

endmodule

// ### bench/msr_props.sv
// Checker for the motion stop reaction block ports
`timescale 1ns/1ps
`include "msr_defines.vh"
module msr_props (
  // Clock and reset
  input ref_clk,
  input reset_n,
  // Parameter port
  input [15:0] parAddr,
  input parWrEn,
  input parErr,
  // Stop requests
  input haltCmd,
  input errClass1,
  input errClass2,
  input quickStopCmd,
  input motorStandstill,
  // External current limits
  input [15:0] motorMaxCurrent,
  input [15:0] stagePeakCurrent,
  input [15:0] i2tCurrent,
  // Reaction outputs
  input haltActive,
  input quickStopActive,
  input torqueRamp,
  input decelRampRunning,
  input [15:0] activeCurrentLimit,
  input [3:0] opState,
  input faultState
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Any quick stop cause
  wire qsReq = quickStopCmd | errClass1 | errClass2;
  // Lower of motor and stage limits
  wire [15:0] minMs = motorMaxCurrent < stagePeakCurrent ? motorMaxCurrent : stagePeakCurrent;
  // Ceiling seen by the block at the last edge; only an upper bound, so reset lag is harmless
  reg [15:0] curCeil_r;
  always @(posedge ref_clk)
  begin
    curCeil_r <= minMs < i2tCurrent ? minMs : i2tCurrent;
  end
  a_qs_start: assert property (qsReq |=> quickStopActive)
    else $error("quick stop not started");
  a_halt_cmd: assert property (haltCmd && !qsReq && !quickStopActive |=> haltActive)
    else $error("fieldbus halt not taken");
  a_halt_limit: assert property (haltActive |-> activeCurrentLimit <= curCeil_r)
    else $error("halt current limit too high");
  a_qs_limit: assert property (quickStopActive |-> activeCurrentLimit <= curCeil_r)
    else $error("quick stop current limit too high");
  a_end_after_stop: assert property ($rose(opState != 4'h0) |-> $past(motorStandstill))
    else $error("end state before standstill");
  a_fault_state: assert property (faultState |-> opState == `MSR_OPST_FAULT && quickStopActive)
    else $error("fault flag without fault state");
  a_sel_refused: assert property (parWrEn && decelRampRunning &&
    (parAddr == `MSR_ADDR_HALT_SEL || parAddr == `MSR_ADDR_QS_SEL) |=> parErr)
    else $error("selector write taken during ramp");
  a_torque_excl: assert property (torqueRamp |-> !decelRampRunning)
    else $error("torque and deceleration ramp together");
endmodule
bind msr_motion_stop_reaction msr_props u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .parAddr(parAddr), .parWrEn(parWrEn),
  .parErr(parErr), .haltCmd(haltCmd), .errClass1(errClass1), .errClass2(errClass2),
  .quickStopCmd(quickStopCmd), .motorStandstill(motorStandstill),
  .motorMaxCurrent(motorMaxCurrent), .stagePeakCurrent(stagePeakCurrent),
  .i2tCurrent(i2tCurrent), .haltActive(haltActive), .quickStopActive(quickStopActive),
  .torqueRamp(torqueRamp), .decelRampRunning(decelRampRunning),
  .activeCurrentLimit(activeCurrentLimit), .opState(opState), .faultState(faultState)
);

// ### bench/msr_bus_master.sv
// Fieldbus master model for the parameter port and stop commands
`timescale 1ns/1ps
module msr_bus_master (
  // Clock
  input ref_clk,
  // Answer from the block
  input [31:0] parRdData,
  input parAck,
  input parErr,
  // Requests to the block
  output logic [15:0] parAddr,
  output logic [31:0] parWrData,
  output logic parWrEn,
  output logic parRdEn,
  output logic haltCmd,
  output logic quickStopCmd
);
  // Idle bus and no commands at time zero
  initial
  begin
    {parAddr, parWrData, parWrEn, parRdEn, haltCmd, quickStopCmd} = '0;
  end
  // One access from edge plus 1 ns; strobe one cycle, answer taken the next
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic k);
  begin
    parWrEn = w;
    parRdEn = !w;
    parAddr = a;
    parWrData = d;
    @(posedge ref_clk);
    #1;
    // Released lines flip so stale values cannot pass
    {parWrEn, parRdEn, parAddr, parWrData} = {2'h0, ~a, ~d};
    {q, e, k} = {parRdData, parErr, parAck};
    // Idle edge, so a following call never re-raises a strobe in this step
    @(posedge ref_clk);
    #1;
  end
  endtask
endmodule

// ### bench/motion_stop_reaction_test.sv
// Self-checking bench for the motion stop reaction block
`timescale 1ns/1ps
module motion_stop_reaction_test;
  // Bench-owned inputs
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic haltPin = 1'h0, errClass1 = 1'h0, errClass2 = 1'h0, stopClear = 1'h0;
  logic motionStart = 1'h0, motorStandstill = 1'h0;
  logic [15:0] motorMaxCurrent = 16'h800, stagePeakCurrent = 16'h900, i2tCurrent = 16'ha00;
  // Block and model nets
  wire [15:0] parAddr, activeCurrentLimit;
  wire [31:0] parWrData, parRdData, activeDecelRate;
  wire parWrEn, parRdEn, parAck, parErr, haltCmd, quickStopCmd;
  wire haltActive, quickStopActive, torqueRamp, decelRampRunning, faultState;
  wire [3:0] opState;
  // Counters and last answer
  int n_fail = 0, comparisons = 0, cyc = 0, i;
  logic [31:0] q;
  logic e, k;
  // Row: write flag, address, data or expected read, expected refusal
  typedef struct {logic w; logic [15:0] a; logic [31:0] d; logic e;} msr_row_t;
  msr_row_t rows [23] = '{
    '{1'h0, 16'h624, 32'h1770, 1'h0},
    '{1'h0, 16'h62e, 32'h1, 1'h0},
    '{1'h0, 16'h630, 32'h6, 1'h0},
    '{1'h0, 16'h111c, 32'h0, 1'h0},
    '{1'h1, 16'h62e, 32'h3, 1'h0},
    '{1'h1, 16'h62e, 32'h2, 1'h1},
    '{1'h0, 16'h62e, 32'h3, 1'h0},
    '{1'h1, 16'h630, 32'hffffffff, 1'h0},
    '{1'h1, 16'h630, 32'hfffffffe, 1'h0},
    '{1'h1, 16'h630, 32'h5, 1'h1},
    '{1'h0, 16'h630, 32'hfffffffe, 1'h0},
    '{1'h1, 16'h624, 32'h0, 1'h1},
    '{1'h1, 16'h624, 32'h80000000, 1'h1},
    '{1'h1, 16'h624, 32'h7fffffff, 1'h0},
    '{1'h0, 16'h624, 32'h7fffffff, 1'h0},
    '{1'h1, 16'h616, 32'h0, 1'h1},
    '{1'h0, 16'h616, 32'h258, 1'h0},
    '{1'h1, 16'h111c, 32'h10000, 1'h1},
    '{1'h1, 16'h111c, 32'h400, 1'h0},
    '{1'h0, 16'h111c, 32'h400, 1'h0},
    '{1'h1, 16'h111a, 32'h500, 1'h0},
    '{1'h1, 16'h700, 32'h0, 1'h1}, // Unmapped address
    '{1'h1, 16'h62e, 32'h1, 1'h0}
  };
  // Block and fieldbus model
  msr_motion_stop_reaction dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .parAddr(parAddr), .parWrData(parWrData),
    .parWrEn(parWrEn), .parRdEn(parRdEn), .parRdData(parRdData), .parAck(parAck),
    .parErr(parErr), .haltPin(haltPin), .haltCmd(haltCmd), .errClass1(errClass1),
    .errClass2(errClass2), .quickStopCmd(quickStopCmd), .stopClear(stopClear),
    .motionStart(motionStart), .motorStandstill(motorStandstill),
    .motorMaxCurrent(motorMaxCurrent), .stagePeakCurrent(stagePeakCurrent),
    .i2tCurrent(i2tCurrent), .haltActive(haltActive), .quickStopActive(quickStopActive),
    .torqueRamp(torqueRamp), .decelRampRunning(decelRampRunning),
    .activeDecelRate(activeDecelRate), .activeCurrentLimit(activeCurrentLimit),
    .opState(opState), .faultState(faultState)
  );
  msr_bus_master bm (
    .ref_clk(ref_clk), .parRdData(parRdData), .parAck(parAck), .parErr(parErr),
    .parAddr(parAddr), .parWrData(parWrData), .parWrEn(parWrEn), .parRdEn(parRdEn),
    .haltCmd(haltCmd), .quickStopCmd(quickStopCmd)
  );
  // Clock of 100 ns
  always #50 ref_clk = ~ref_clk;
  // Value compare, counted
  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Advance to n edges later plus the drive delay
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Verdict and end of run
  task complete_run;
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      complete_run;
    end
  end
  // Main sequence
  initial
  begin
    tick(5);
    reset_n = 1'h1;
    chk(activeDecelRate, 32'h258);
    chk(opState, 4'h0);
    for (i = 0; i < 23; i++)
    begin
      bm.acc(rows[i].w, rows[i].a, rows[i].d, q, e, k);
      chk(k, 1'h1);
      chk(e, rows[i].e);
      if (!rows[i].w)
        chk(q, rows[i].d);
    end
    // Latch rates, then change the quick rate for the next start only
    motionStart = 1'h1;
    tick(1);
    motionStart = 1'h0;
    bm.acc(1'h1, 16'h624, 32'h1000, q, e, k);
    // Fieldbus halt on a deceleration ramp; selectors locked meanwhile
    bm.haltCmd = 1'h1;
    tick(1);
    chk(haltActive, 1'h1);
    chk(decelRampRunning, 1'h1);
    chk(activeCurrentLimit, 16'h400);
    chk(activeDecelRate, 32'h258);
    bm.acc(1'h1, 16'h62e, 32'h3, q, e, k);
    chk(e, 1'h1);
    bm.acc(1'h1, 16'h630, 32'h7, q, e, k);
    chk(e, 1'h1);
    bm.acc(1'h0, 16'h62e, 32'h0, q, e, k);
    chk(q, 32'h1);
    bm.haltCmd = 1'h0;
    tick(1);
    chk(haltActive, 1'h0);
    // Pin halt on the torque ramp, through the input synchroniser
    bm.acc(1'h1, 16'h62e, 32'h3, q, e, k);
    haltPin = 1'h1;
    tick(2);
    chk(haltActive, 1'h0);
    tick(1);
    chk(haltActive, 1'h1);
    chk(torqueRamp, 1'h1);
    bm.acc(1'h1, 16'h630, 32'h6, q, e, k);
    chk(e, 1'h0);
    // Standstill during halt holds the halt, still resumable
    motorStandstill = 1'h1;
    tick(1);
    motorStandstill = 1'h0;
    tick(1);
    chk(haltActive, 1'h1);
    chk(activeCurrentLimit, 16'h400);
    haltPin = 1'h0;
    tick(3);
    chk(haltActive, 1'h0);
    // Quick stop codes 6, -1, -2, 7 from rotating causes, halt held meanwhile
    i2tCurrent = 16'h300;
    for (i = 0; i < 4; i++)
    begin
      bm.acc(1'h1, 16'h630, i == 0 ? 32'h6 : i == 3 ? 32'h7 : {31'h7fffffff, i == 1}, q, e, k);
      bm.haltCmd = 1'h1;
      case (i % 3)
        0: bm.quickStopCmd = 1'h1;
        1: errClass1 = 1'h1;
        default: errClass2 = 1'h1;
      endcase
      tick(1);
      {bm.quickStopCmd, errClass1, errClass2} = 3'h0;
      chk(quickStopActive, 1'h1);
      chk(haltActive, 1'h0);
      chk(torqueRamp, i > 1);
      chk(decelRampRunning, i < 2);
      chk(activeCurrentLimit, 16'h300);
      chk(activeDecelRate, i ? 32'h1000 : 32'h7fffffff);
      tick(2);
      chk(opState, 4'h0);
      motorStandstill = 1'h1;
      tick(1);
      motorStandstill = 1'h0;
      chk(opState, (i == 1 || i == 2) ? 4'h9 : 4'h7);
      chk(faultState, i == 1 || i == 2);
      bm.haltCmd = 1'h0;
      stopClear = 1'h1;
      tick(1);
      stopClear = 1'h0;
      chk(quickStopActive, 1'h0);
      motionStart = 1'h1;
      tick(1);
      motionStart = 1'h0;
    end
    complete_run;
  end
endmodule
